// ---- hw/nerr_pkg.sv ----
// constants and helpers for the nand ecc error report block
// assumes a 32-bit register port with byte addresses and one system clock
package nerr_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_FLAGS_HI  = 8'h00;
    localparam logic [7:0] OFF_LOCATION  = 8'h04;
    localparam logic [7:0] OFF_CTRL      = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h0c;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h10;
    localparam logic [7:0] OFF_PAR_BASE  = 8'h20;  // eight sector parity words
    localparam logic [7:0] OFF_PAR_LAST  = 8'h3c;

    // sector error group layout
    localparam int         GRP_W         = 4;
    localparam int         GRP_REC       = 0;
    localparam int         GRP_ECC       = 1;
    localparam int         GRP_MUL       = 2;
    localparam int         NUM_SECT      = 8;
    localparam logic [3:0] FIRST_SECT    = 4'h8;
    localparam int         PAR_LOC_W     = 24;

    // single ecc location register layout
    localparam int         BIT_LSB       = 0;
    localparam int         BIT_W         = 4;
    localparam int         WORD_LSB      = 4;
    localparam int         WORD_W        = 12;

    // control register fields
    localparam int         CTRL_CORR     = 0;   // 1 = one ecc per sector
    localparam int         CTRL_WIDE     = 1;   // 1 = 16-bit flash words
    localparam logic [1:0] CTRL_RESET    = 2'h0;

    // interrupt status bits
    localparam int         IRQ_W         = 3;
    localparam int         IRQ_DONE      = 0;
    localparam int         IRQ_SINGLE    = 1;
    localparam int         IRQ_MULTI     = 2;
    localparam logic [2:0] IRQ_RESET     = 3'h0;

    // packs one sector group, reserved top bit zero
    function automatic logic [3:0] grp_pack(
        input logic rec,
        input logic ecc,
        input logic mul
    );
        grp_pack = {1'b0, mul, ecc, rec};
    endfunction

endpackage

// ---- hw/nerr_res_if.sv ----
// result channel between the report front end and the sector log
// assumes both ends share ref_clk
`timescale 1ns/1ps
interface nerr_res_if;
    logic        page_start;
    logic        valid;
    logic [2:0]  sect;
    logic        rec;
    logic        ecc;
    logic        mul;
    logic [23:0] par_loc;
    logic [2:0]  rd_sect;
    logic [31:0] flags;
    logic [23:0] rd_loc;

    modport src
    (
        output page_start,
        output valid,
        output sect,
        output rec,
        output ecc,
        output mul,
        output par_loc,
        output rd_sect,
        input  flags,
        input  rd_loc
    );
    modport log
    (
        input  page_start,
        input  valid,
        input  sect,
        input  rec,
        input  ecc,
        input  mul,
        input  par_loc,
        input  rd_sect,
        output flags,
        output rd_loc
    );
endinterface

// ---- hw/nerr_sector_log.sv ----
// per-sector flag and parity location store for sectors 8 to 15
// assumes results arrive as one-cycle strobes from the front end
`timescale 1ns/1ps
module nerr_sector_log
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    nerr_res_if.log   res
);
    logic [3:0]  grp_q [nerr_pkg::NUM_SECT];
    logic [23:0] loc_q [nerr_pkg::NUM_SECT];

    // group k lands at bits 4k+3..4k
    always_comb
    begin
        res.flags = '0;
        for (int k = 0; k < nerr_pkg::NUM_SECT; k++)
        begin
            res.flags[k*nerr_pkg::GRP_W +: nerr_pkg::GRP_W] = grp_q[k];  // [R1] [R2]
        end
    end

    assign res.rd_loc = loc_q[res.rd_sect];

    // new page clears, each result overwrites its sector
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int k = 0; k < nerr_pkg::NUM_SECT; k++)
            begin
                grp_q[k] <= 4'h0;
                loc_q[k] <= 24'h000000;
            end
        end
        else if (res.page_start)
        begin
            for (int k = 0; k < nerr_pkg::NUM_SECT; k++)
            begin
                grp_q[k] <= 4'h0;
                loc_q[k] <= 24'h000000;
            end
        end
        else if (res.valid)
        begin
            grp_q[res.sect] <= nerr_pkg::grp_pack(res.rec, res.ecc, res.mul);  // [R4] [R5] [R7]
            loc_q[res.sect] <= res.ecc ? res.par_loc : 24'h000000;            // [R6]
        end
    end
endmodule

// ---- hw/nerr_report.sv ----
// error report registers of the nand ecc unit
// assumes a syndrome stage that strobes one result per sector after a page read,
// and a register master using the plain one-cycle strobe port
//
// Behaviour
// R1 - flags kept for sectors 8 to 15
// R2 - group k at bits 4k..4k+2, 4k+3 zero
// R3 - single page ecc mode reads flags zero
// R4 - recoverable flag set when errors found
// R5 - ecc byte flag on parity byte error
// R6 - failing parity bit marked in low 24
// R7 - multiple flag set on more than one
// R8 - separate layout for one ecc per page
// R9 - host saves parity into spare area
// R10 - bit offset loaded on single error
// R11 - word address loaded, 8 or 16 bit
// R12 - host ignores location on multiple errors
// R13 - bit offset 3:0, word 15:4, rest zero
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module nerr_report
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        page_start,
    input  wire logic        res_valid,
    input  wire logic [3:0]  res_sector,
    input  wire logic        res_err,
    input  wire logic        res_ecc_byte,
    input  wire logic        res_multi,
    input  wire logic [2:0]  res_bit,
    input  wire logic [11:0] res_byte_addr,
    input  wire logic [23:0] res_parity_loc,
    output logic             irq
);
    nerr_res_if res ();

    logic [1:0]  ctrl_q;
    logic [1:0]  ctrl_d;
    logic [15:0] loc_q;
    logic [15:0] loc_d;
    logic [2:0]  stat_q;
    logic [2:0]  stat_d;
    logic [2:0]  mask_q;
    logic [2:0]  mask_d;
    logic [31:0] rdata_d;
    logic        irq_d;

    // mode decode
    wire         per_sector  = ctrl_q[nerr_pkg::CTRL_CORR];
    wire         wide        = ctrl_q[nerr_pkg::CTRL_WIDE];
    wire         hi_sector   = res_sector[3];
    wire         single_hit  = res_valid && res_err && !res_multi;
    wire         multi_hit   = res_valid && res_multi;

    // word and bit position, 16-bit words halve the byte address
    wire [11:0]  word_addr   = wide ? {1'b0, res_byte_addr[11:1]} : res_byte_addr;  // [R11]
    wire [3:0]   bit_offset  = wide ? {res_byte_addr[0], res_bit} : {1'b0, res_bit}; // [R10]

    // results toward the sector log
    assign res.page_start = page_start;
    assign res.valid      = res_valid && per_sector && hi_sector;  // [R1]
    assign res.sect       = res_sector[2:0];
    assign res.rec        = res_err || res_multi;                  // [R4]
    assign res.ecc        = res_ecc_byte && res_err && !res_multi; // [R5]
    assign res.mul        = res_multi;                             // [R7]
    assign res.par_loc    = res_parity_loc;
    assign res.rd_sect    = reg_addr[4:2];

    nerr_sector_log u_log
    (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .res     (res)
    );

    // address decode
    wire         hit_flags   = reg_addr == nerr_pkg::OFF_FLAGS_HI;
    wire         hit_loc     = reg_addr == nerr_pkg::OFF_LOCATION;
    wire         hit_ctrl    = reg_addr == nerr_pkg::OFF_CTRL;
    wire         hit_stat    = reg_addr == nerr_pkg::OFF_IRQ_STAT;
    wire         hit_mask    = reg_addr == nerr_pkg::OFF_IRQ_MASK;
    wire         hit_par     = reg_addr >= nerr_pkg::OFF_PAR_BASE
                               && reg_addr <= nerr_pkg::OFF_PAR_LAST
                               && reg_addr[1:0] == 2'h0;

    // flags read zero while one ecc covers the page
    wire [31:0]  flags_view  = per_sector ? res.flags : 32'h00000000;       // [R3] [R2]
    wire [31:0]  loc_view    = {16'h0000, loc_q};                            // [R13] [R8]
    wire [31:0]  par_view    = per_sector ? {8'h00, res.rd_loc} : 32'h00000000; // [R6]

    // read mux, unmapped reads zero
    assign rdata_d = !reg_rd  ? 32'h00000000 :
                     hit_flags ? flags_view :
                     hit_loc   ? loc_view :
                     hit_ctrl  ? {30'h00000000, ctrl_q} :
                     hit_stat  ? {29'h00000000, stat_q} :
                     hit_mask  ? {29'h00000000, mask_q} :
                     hit_par   ? par_view : 32'h00000000;

    // control write
    assign ctrl_d = (reg_wr && hit_ctrl) ? reg_wdata[1:0] : ctrl_q;

    // single ecc location: only a single data error loads it
    assign loc_d = (single_hit && !per_sector && !res_ecc_byte)
                   ? {word_addr, bit_offset} : loc_q;                        // [R10] [R11] [R13]

    // events, set wins over write-one clear
    wire [2:0]   ev          = {multi_hit, single_hit, res_valid};
    wire [2:0]   clr         = (reg_wr && hit_stat) ? reg_wdata[2:0] : 3'h0;
    assign stat_d = (stat_q & ~clr) | ev;
    assign mask_d = (reg_wr && hit_mask) ? reg_wdata[2:0] : mask_q;
    assign irq_d  = |(stat_d & mask_d);

    // register state
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q    <= nerr_pkg::CTRL_RESET;
            loc_q     <= 16'h0000;
            stat_q    <= nerr_pkg::IRQ_RESET;
            mask_q    <= nerr_pkg::IRQ_RESET;
            reg_rdata <= 32'h00000000;
            irq       <= 1'b0;
        end
        else
        begin
            ctrl_q    <= ctrl_d;
            loc_q     <= loc_d;
            stat_q    <= stat_d;
            mask_q    <= mask_d;
            reg_rdata <= rdata_d;
            irq       <= irq_d;
        end
    end
endmodule

// ---- sim/nerr_report_sva.sv ----
// assertions on the ports of nerr_report
// assumes one ref_clk domain and active-low nrst
`timescale 1ns/1ps
module nerr_report_chk
(
    input wire logic        ref_clk, nrst, reg_wr, reg_rd, page_start, res_valid,
    input wire logic        res_err, res_ecc_byte, res_multi, irq,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata, reg_rdata,
    input wire logic [3:0]  res_sector,
    input wire logic [2:0]  res_bit,
    input wire logic [11:0] res_byte_addr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    logic mode_q, wide_q;
    // shadow of the two mode bits
    always_ff @(posedge ref_clk or negedge nrst)
        if (!nrst)
            {wide_q, mode_q} <= 2'h0;
        else if (reg_wr && reg_addr == 8'h08)
            {wide_q, mode_q} <= reg_wdata[1:0];
    // high sector result read back on the next cycle
    sequence s_hit(x);
        res_valid && x && mode_q && res_sector[3] && !page_start
        ##1 reg_rd && reg_addr == 8'h00 && mode_q && !res_valid && !page_start;
    endsequence
    property p_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("stray read data");
    property p_grp; reg_rd && reg_addr == 8'h00 |=> !(reg_rdata & 32'h8888_8888); endproperty
    a_grp: assert property (p_grp) else $error("group top bit set");
    property p_hi; reg_rd && reg_addr == 8'h04 |=> reg_rdata[31:16] == 16'h0; endproperty
    a_hi: assert property (p_hi) else $error("location top half set");
    property p_off; reg_rd && reg_addr == 8'h00 && !mode_q |=> reg_rdata == 32'h0; endproperty
    a_off: assert property (p_off) else $error("flags in page mode");
    property p_rec; s_hit(res_err) |=> reg_rdata[{$past(res_sector[2:0], 2), 2'b00}]; endproperty
    a_rec: assert property (p_rec) else $error("recoverable flag missing");
    property p_mul; s_hit(res_multi) |=> reg_rdata[{$past(res_sector[2:0], 2), 2'b10}]; endproperty
    a_mul: assert property (p_mul) else $error("multiple flag missing");
    property p_loc;
        res_valid && res_err && !res_multi && !res_ecc_byte && !mode_q && !wide_q && !page_start
        ##1 reg_rd && reg_addr == 8'h04 && !res_valid && !page_start
        |=> reg_rdata[15:0] == {$past(res_byte_addr, 2), 1'b0, $past(res_bit, 2)};
    endproperty
    a_loc: assert property (p_loc) else $error("wrong error location");
    property p_irq;
        $changed(irq) |-> $past(reg_wr) || $rose(irq) && $past(res_valid);
    endproperty
    a_irq: assert property (p_irq) else $error("irq moved without cause");
endmodule
bind nerr_report nerr_report_chk chk (.*);

// ---- sim/nerr_page_src.sv ----
// result source standing in for the syndrome stage
// assumes its tasks are called just after a rising edge
`timescale 1ns/1ps
module nerr_page_src
(
    input  wire logic   ref_clk,
    output logic        page_start, res_valid, res_err, res_ecc_byte, res_multi,
    output logic [3:0]  res_sector,
    output logic [2:0]  res_bit,
    output logic [11:0] res_byte_addr,
    output logic [23:0] res_parity_loc
);
    // quiet at time zero
    initial
        {page_start, res_valid, res_err, res_ecc_byte, res_multi, res_sector,
         res_bit, res_byte_addr, res_parity_loc} = '0;
    // new page pulse
    task automatic page();
        page_start <= 1'b1;
        @(posedge ref_clk);
        page_start <= 1'b0;
        @(posedge ref_clk);
    endtask
    // one result for one cycle, then fields scrambled
    task automatic put(input logic [3:0] s, input logic [2:0] k, input logic [2:0] b,
                       input logic [11:0] a, input logic [23:0] l);
        {res_valid, res_sector, res_multi, res_ecc_byte, res_err} <= {1'b1, s, k};
        {res_bit, res_byte_addr, res_parity_loc} <= {b, a, l};
        @(posedge ref_clk);
        res_valid <= 1'b0;
        {res_sector, res_bit, res_byte_addr, res_parity_loc} <= ~{s, b, a, l};
    endtask
endmodule

// ---- sim/tb_nerr_report.sv ----
// bench for nerr_report, reads queued and checked on return
// assumes nerr_page_src and the bound checker
`timescale 1ns/1ps
module tb_nerr_report;
    logic        ref_clk, nrst, reg_wr, reg_rd, pend, irq;
    logic        page_start, res_valid, res_err, res_ecc_byte, res_multi;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, e, f, q[$];
    logic [3:0]  res_sector;
    logic [2:0]  res_bit;
    logic [11:0] res_byte_addr;
    logic [23:0] res_parity_loc, par;
    int          failures, comparisons, cycles, k;
    integer      seed;
    nerr_report   dut (.*);
    nerr_page_src src (.*);
    // clock
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic cmp(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic cmp_irq(input logic g, input logic x);
        comparisons++;
        if (g !== x)
        begin
            failures++;
            $display("Error at %0t: irq got %h expected %h", $time, g, x);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one register write or read, a read queues its expectation
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        if (!w)
            q.push_back(d);
        @(posedge ref_clk);
        {reg_wr, reg_rd} <= 2'h0;
        @(posedge ref_clk);
    endtask
    // read answers one cycle after the strobe, and the hang limit
    always @(posedge ref_clk)
    begin
        if (pend)
            cmp(reg_rdata, q.pop_front());
        pend <= reg_rd;
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            wrap_up();
        end
    end
    initial
    begin
        {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, pend} = '0;
        seed = 32'h4731;
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        // reset values after a read-only and an unmapped write
        acc(1'b1, 8'h00, 32'hffff_ffff);
        acc(1'b1, 8'h44, 32'hffff_ffff);
        for (k = 0; k < 18; k++)
            acc(1'b0, 8'(4 * k), 32'h0);
        // one ecc per page, byte then halfword words
        for (k = 0; k < 2; k++)
        begin
            acc(1'b1, 8'h08, 32'(2 * k));
            e = $random(seed);
            f = k ? {17'h0, e[15:5], e[4], e[2:0]} : {16'h0, e[15:4], 1'b0, e[2:0]};
            src.put(4'h9, 3'b001, e[2:0], e[15:4], 24'h1);
            acc(1'b0, 8'h04, f);
            src.put(4'h9, 3'b101, e[5:3], e[11:0], 24'h1); // location left unread
            acc(1'b0, 8'h00, 32'h0);
        end
        // one ecc per sector, each kind once, low sectors ignored
        acc(1'b1, 8'h08, 32'h1);
        src.page();
        f = 32'h0;
        for (k = 0; k < 8; k++)
        begin
            e = $random(seed);
            src.put(4'(k), 3'b111, e[2:0], e[15:4], 24'h1);
            acc(1'b0, 8'h00, f);
            f[4 * k +: 4] = {1'b0, k[2], k == 3, k[0] | k[2]};
            src.put(4'(8 + k), k[2:0], e[2:0], e[15:4], 24'h1 << (e[7:3] % 24));
            acc(1'b0, 8'h00, f);
            if (k == 3)
                par = 24'h1 << (e[7:3] % 24);
        end
        for (k = 0; k < 8; k++)
            acc(1'b0, 8'h20 + 8'(4 * k), k == 3 ? {8'h0, par} : 32'h0);
        src.page();
        acc(1'b0, 8'h00, 32'h0);
        // interrupt raised, masked, unmasked, cleared
        acc(1'b1, 8'h0c, 32'h7);
        acc(1'b1, 8'h10, 32'h1);
        src.put(4'h8, 3'b001, 3'h0, 12'h0, 24'h1);
        for (k = 0; k < 4; k++)
        begin
            if (k > 0)
                acc(1'b1, k == 3 ? 8'h0c : 8'h10, 32'(k > 1));
            repeat (2) @(posedge ref_clk);
            #1 cmp_irq(irq, !k[0]);
        end
        // single event bit left set, result bit cleared, mask kept
        acc(1'b0, 8'h0c, 32'h2);
        acc(1'b0, 8'h10, 32'h1);
        @(posedge ref_clk);
        wrap_up();
    end
endmodule
